/* card_disable_pkg.sv */
// Purpose: Shared constants for the card forced-disable block
// Assumes: 32-bit classic Wishbone register bus, 250 MHz clock
// Notes: Register offsets are byte addresses
package card_disable_pkg;
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AW-1:0] STAT_OFS = 8'h04;
  localparam logic [AW-1:0] ACC_OFS = 8'h08;
  localparam logic [AW-1:0] ANS_OFS = 8'h0C;
  // Control fields
  localparam int unsigned CTRL_REQ_BIT = 0;
  localparam int unsigned CTRL_USE_BIT = 1;
  // Status fields
  localparam int unsigned ST_DIS_BIT = 0;
  localparam int unsigned ST_PRES_BIT = 1;
  localparam int unsigned ST_WP_BIT = 2;
  localparam int unsigned ST_STOP_BIT = 3;
  localparam int unsigned ST_BUSY_BIT = 4;
  // Access register fields
  localparam int unsigned ACC_OP_LSB = 0;
  localparam int unsigned ACC_OP_W = 3;
  // Access answer codes
  localparam logic [3:0] ANS_OK = 4'h0;
  localparam logic [3:0] ANS_NO_CARD = 4'h1;
  localparam logic [3:0] ANS_SKIPPED = 4'h2;
  localparam logic [3:0] ANS_PROTECT = 4'h3;
  localparam logic [3:0] ANS_NONE = 4'hF;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_ERASE, OP_FILE_READ, OP_FILE_WRITE,
    OP_COMMENT_READ, OP_COMMENT_SET, OP_NOP
  } card_op_t;
  function automatic logic op_modifies(input card_op_t op);
    op_modifies = (op == OP_WRITE) || (op == OP_ERASE) ||
      (op == OP_FILE_WRITE) || (op == OP_COMMENT_SET);
  endfunction : op_modifies
  function automatic logic op_special(input card_op_t op);
    op_special = (op == OP_FILE_READ) || (op == OP_FILE_WRITE) ||
      (op == OP_COMMENT_READ) || (op == OP_COMMENT_SET);
  endfunction : op_special
endpackage : card_disable_pkg

/* disable_ctrl.sv */
// Purpose: Forced-disable state machine for the card
// Assumes: Request level from software, one clock
// Notes: Request toggles are ignored until status has followed
`timescale 1ns/1ps
module disable_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic force_disable_request_i,
  input wire logic lock_stop_i,
  // State
  output logic disabled_o,
  output logic usable_o
);
  import card_disable_pkg::*;
  typedef enum logic [1:0] {S_RUN, S_ENTER, S_DIS, S_HOLD} dis_state_t;
  dis_state_t state_r, state_nxt;
  logic disabled_r, disabled_nxt;
  always_comb begin
    state_nxt = state_r;
    disabled_nxt = disabled_r;
    case (state_r)
      S_RUN: begin
        if (force_disable_request_i) begin
          state_nxt = S_ENTER;
        end
      end
      S_ENTER: begin
        // Disable applies regardless of the use condition
        state_nxt = S_DIS;
        disabled_nxt = 1'b1;
      end
      S_DIS: begin
        if (!force_disable_request_i) begin
          // Leave disable on request clear, or keep it in S_HOLD while lock stop is set
          state_nxt = lock_stop_i ? S_HOLD : S_RUN;
          disabled_nxt = lock_stop_i;
        end
      end
      S_HOLD: begin
        // Usable only when the lock is released too
        if (force_disable_request_i) begin
          state_nxt = S_DIS;
        end else if (!lock_stop_i) begin
          state_nxt = S_RUN;
          disabled_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = S_RUN;
        disabled_nxt = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= S_RUN;
      disabled_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      disabled_r <= disabled_nxt;
    end
  end
  assign disabled_o = disabled_r;
  assign usable_o = !disabled_r && !lock_stop_i;
endmodule : disable_ctrl

/* access_gate.sv */
// Purpose: Answers card accesses according to card state
// Assumes: One access request pulse at a time
// Notes: Answer is registered one cycle after the request
`timescale 1ns/1ps
module access_gate (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request
  input wire logic req_i,
  input wire logic [2:0] op_i,
  // Card state
  input wire logic present_i,
  input wire logic disabled_i,
  input wire logic lock_stop_i,
  input wire logic write_protect_i,
  // Answer
  output logic done_o,
  output logic [3:0] answer_o,
  output logic card_go_o
);
  import card_disable_pkg::*;
  logic done_r, done_nxt;
  logic [3:0] ans_r, ans_nxt;
  logic go_r, go_nxt;
  card_op_t op;
  always_comb begin
    op = card_op_t'(op_i);
    done_nxt = req_i;
    ans_nxt = ans_r;
    go_nxt = 1'b0;
    if (req_i) begin
      if (disabled_i && op_special(op)) begin
        ans_nxt = ANS_SKIPPED;
      end else if (disabled_i || !present_i || lock_stop_i) begin
        ans_nxt = ANS_NO_CARD;
      end else if (write_protect_i && op_modifies(op)) begin
        ans_nxt = ANS_PROTECT;
      end else begin
        ans_nxt = ANS_OK;
        go_nxt = (op != OP_NOP);
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_r <= 1'b0;
      ans_r <= ANS_NONE;
      go_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      ans_r <= ans_nxt;
      go_r <= go_nxt;
    end
  end
  assign done_o = done_r;
  assign answer_o = ans_r;
  assign card_go_o = go_r;
endmodule : access_gate

/* card_disable.sv */
// Purpose: Card forced-disable control with Wishbone registers
// Assumes: Classic Wishbone slave, synchronous inputs
// Notes: Ack comes one cycle after the strobe
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
// Function
// - Stop card operation when request set
// - Readable status flag shows forced disable
// - Activity indicator off while disabled
// - Disable works even while card in use
// - Power cycle, reset or clear cancels
// - Ignore request toggles until status follows
// - Accesses answered as if no card
// - File and comment instructions skipped, distinct
// - Lock stop needs release and clear
// - Write protect rejects erase and modify
module card_disable (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [card_disable_pkg::AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Card slot
  input wire logic card_present_i,
  input wire logic write_protect_i,
  input wire logic lock_stop_i,
  input wire logic card_activity_i,
  // Card side
  output logic card_go_o,
  output logic card_enable_o,
  output logic activity_led_o
);
  import card_disable_pkg::*;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic req_r, req_nxt;
  logic use_r, use_nxt;
  logic acc_req_r, acc_req_nxt;
  logic [ACC_OP_W-1:0] acc_op_r, acc_op_nxt;
  logic busy_r, busy_nxt;
  logic led_r, led_nxt;
  logic en_r, en_nxt;
  logic disabled;
  logic usable;
  logic done;
  logic [3:0] answer;
  logic go;
  logic [3:0] ans_r, ans_nxt;
  logic go_r, go_nxt;
  logic wr_hit;
  logic rd_hit;

  disable_ctrl u_ctrl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .force_disable_request_i(req_r),
    .lock_stop_i(lock_stop_i),
    .disabled_o(disabled),
    .usable_o(usable)
  );

  access_gate u_gate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(acc_req_r),
    .op_i(acc_op_r),
    .present_i(card_present_i),
    .disabled_i(disabled),
    .lock_stop_i(lock_stop_i),
    .write_protect_i(write_protect_i),
    .done_o(done),
    .answer_o(answer),
    .card_go_o(go)
  );

  assign wr_hit = cyc_i && stb_i && we_i && ack_r;
  assign rd_hit = cyc_i && stb_i && !we_i && !ack_r;

  // Bus registers and access launch
  always_comb begin
    ack_nxt = cyc_i && stb_i && !ack_r;
    dat_nxt = dat_r;
    req_nxt = req_r;
    use_nxt = use_r;
    acc_req_nxt = 1'b0;
    acc_op_nxt = acc_op_r;
    busy_nxt = busy_r;
    ans_nxt = ans_r;
    if (wr_hit && sel_i[0]) begin
      case (adr_i)
        CTRL_OFS: begin
          req_nxt = dat_i[CTRL_REQ_BIT];
          use_nxt = dat_i[CTRL_USE_BIT];
        end
        ACC_OFS: begin
          if (!busy_r) begin
            acc_req_nxt = 1'b1;
            acc_op_nxt = dat_i[ACC_OP_LSB +: ACC_OP_W];
            busy_nxt = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (done) begin
      busy_nxt = 1'b0;
      ans_nxt = answer;
    end
    if (rd_hit) begin
      case (adr_i)
        CTRL_OFS: begin
          dat_nxt = 32'h0000_0000;
          dat_nxt[CTRL_REQ_BIT] = req_r;
          dat_nxt[CTRL_USE_BIT] = use_r;
        end
        STAT_OFS: begin
          dat_nxt = 32'h0000_0000;
          dat_nxt[ST_DIS_BIT] = disabled;
          dat_nxt[ST_PRES_BIT] = card_present_i;
          dat_nxt[ST_WP_BIT] = write_protect_i;
          dat_nxt[ST_STOP_BIT] = lock_stop_i;
          dat_nxt[ST_BUSY_BIT] = busy_r;
        end
        ACC_OFS: begin
          dat_nxt = 32'h0000_0000;
          dat_nxt[ACC_OP_LSB +: ACC_OP_W] = acc_op_r;
        end
        ANS_OFS: begin
          dat_nxt = {28'h000_0000, ans_r};
        end
        default: begin
          dat_nxt = RD_UNMAPPED;
        end
      endcase
    end
  end

  // Card-facing outputs
  always_comb begin
    go_nxt = go && !disabled;
    en_nxt = usable;
    led_nxt = card_activity_i && use_r && !disabled;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      req_r <= 1'b0;
      use_r <= 1'b0;
      acc_req_r <= 1'b0;
      acc_op_r <= 3'h0;
      busy_r <= 1'b0;
      ans_r <= ANS_NONE;
      go_r <= 1'b0;
      en_r <= 1'b0;
      led_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      req_r <= req_nxt;
      use_r <= use_nxt;
      acc_req_r <= acc_req_nxt;
      acc_op_r <= acc_op_nxt;
      busy_r <= busy_nxt;
      ans_r <= ans_nxt;
      go_r <= go_nxt;
      en_r <= en_nxt;
      led_r <= led_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign card_go_o = go_r;
  assign card_enable_o = en_r;
  assign activity_led_o = led_r;
endmodule : card_disable

/* card_disable_assertions.sv */
// Purpose: Port checks for card_disable
// Assumes: One clock, synchronous reset
// Notes: Bound to every card_disable
`timescale 1ns/1ps
module card_disable_assertions (
  // Bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Card
  input wire logic lock_stop_i,
  input wire logic card_activity_i,
  input wire logic card_go_o,
  input wire logic card_enable_o,
  input wire logic activity_led_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_dark;
    (!lock_stop_i && !card_enable_o) [*3];
  endsequence
  a_ack_next: assert property (s_take |=> ack_o ##1 !ack_o)
    else $error("bad ack pulse");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("stray ack");
  a_dat_hold: assert property (!(cyc_i && stb_i && !we_i && !ack_o)
    |=> $stable(dat_o)) else $error("read data moved");
  a_led_cause: assert property (
    activity_led_o |-> $past(card_activity_i)) else $error("led no cause");
  a_dark_led: assert property (s_dark |-> !activity_led_o)
    else $error("led lit while off");
  a_stop_off: assert property (lock_stop_i [*3] |-> !card_enable_o)
    else $error("enabled in stop");
  a_go_pulse: assert property (card_go_o |=> !card_go_o)
    else $error("go too long");
  a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !ack_o && !card_go_o && !card_enable_o && !activity_led_o)
    else $error("outputs live in reset");
endmodule : card_disable_assertions
bind card_disable card_disable_assertions u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .dat_o(dat_o), .ack_o(ack_o), .lock_stop_i(lock_stop_i),
  .card_activity_i(card_activity_i), .card_go_o(card_go_o),
  .card_enable_o(card_enable_o), .activity_led_o(activity_led_o));

/* card_slot_model.sv */
// Purpose: Card slot model on the card pins
// Assumes: Card always inserted
// Notes: A forwarded access keeps the card busy three cycles
`timescale 1ns/1ps
module card_slot_model (
  // Clock and access
  input wire logic clk_i,
  input wire logic go_i,
  // Bench controls
  input wire logic wp_set_i,
  input wire logic stop_set_i,
  input wire logic busy_set_i,
  // Card pins
  output logic present_o,
  output logic wp_o,
  output logic stop_o,
  output logic activity_o
);
  int go_cnt = 0;
  logic [1:0] burst_r = 2'h0;
  assign present_o = 1'h1;
  assign wp_o = wp_set_i;
  assign stop_o = stop_set_i;
  assign activity_o = busy_set_i | (burst_r != 2'h0);
  always @(posedge clk_i) begin
    if (go_i) begin
      go_cnt <= go_cnt + 1;
      burst_r <= 2'h3;
    end else if (burst_r != 2'h0) begin
      burst_r <= burst_r - 2'h1;
    end
  end
endmodule : card_slot_model

/* card_disable_bench.sv */
// Purpose: Self-checking bench for card_disable
// Assumes: Slot model on the card pins
// Notes: Expected answers come from a small model
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module card_disable_bench;
  import card_disable_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
  logic we_i = 1'h0, wp = 1'h0, stop = 1'h0, busy = 1'h0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, q, r;
  logic ack_o, go, en, led, pres, wpl, stp, act;
  int n_fail = 0, n_tests = 0, ticks = 0, i, seed;
  int dis_m = 0, stop_m = 0, wp_m = 0, en_low = 0, e0 = 0;
  always #2 clk_i = ~clk_i;
  card_disable dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .card_present_i(pres),
    .write_protect_i(wpl), .lock_stop_i(stp), .card_activity_i(act),
    .card_go_o(go), .card_enable_o(en), .activity_led_o(led));
  card_slot_model slot (.clk_i(clk_i), .go_i(go), .wp_set_i(wp),
    .stop_set_i(stop), .busy_set_i(busy), .present_o(pres), .wp_o(wpl),
    .stop_o(stp), .activity_o(act));
  task automatic tally_and_finish;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_i) begin
    ticks++;
    if (en === 1'h0) en_low++;
    if (ticks == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'h1);
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask : wb
  function automatic logic [3:0] exp_ans(input int op);
    if (dis_m != 0) begin
      return (op inside {3, 4, 5, 6}) ? ANS_SKIPPED : ANS_NO_CARD;
    end
    if (stop_m != 0) return ANS_NO_CARD;
    if (wp_m != 0 && op inside {1, 2, 4, 6}) return ANS_PROTECT;
    return ANS_OK;
  endfunction : exp_ans
  task automatic acc(input int op);
    int g;
    g = slot.go_cnt;
    wb(1'h1, ACC_OFS, 32'(op), q);
    repeat (4) @(posedge clk_i);
    wb(1'h0, ANS_OFS, 32'h0, q);
    `CHK(q[3:0], exp_ans(op))
    `CHK(slot.go_cnt - g, int'(exp_ans(op) == ANS_OK && op != 7))
  endtask : acc
  initial begin
    seed = 32'hF4A4F670;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    wb(1'h0, 8'h10, 32'h0, q);
    `CHK(q, RD_UNMAPPED)
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      wp <= r[0];
      wp_m = r[0];
      acc(i);
    end
    wp <= 1'h0;
    wp_m = 0;
    busy <= 1'h1;
    wb(1'h1, CTRL_OFS, 32'h2, q);
    repeat (3) @(posedge clk_i);
    `CHK(led, 1'h1)
    wb(1'h1, CTRL_OFS, 32'h3, q);
    dis_m = 1;
    repeat (3) @(posedge clk_i);
    wb(1'h0, STAT_OFS, 32'h0, q);
    `CHK(q[0], 1'h1)
    `CHK({en, led}, 2'h0)
    for (i = 0; i < 8; i++) acc(i);
    busy <= 1'h0;
    wb(1'h1, CTRL_OFS, 32'h0, q);
    dis_m = 0;
    repeat (3) @(posedge clk_i);
    `CHK(en, 1'h1)
    e0 = en_low;
    wb(1'h1, CTRL_OFS, 32'h1, q);
    wb(1'h1, CTRL_OFS, 32'h0, q);
    repeat (3) @(posedge clk_i);
    `CHK(int'(en_low > e0), 1)
    `CHK(en, 1'h1)
    acc(4);
    stop <= 1'h1;
    stop_m = 1;
    acc(0);
    wb(1'h1, CTRL_OFS, 32'h1, q);
    wb(1'h1, CTRL_OFS, 32'h0, q);
    repeat (3) @(posedge clk_i);
    wb(1'h0, STAT_OFS, 32'h0, q);
    `CHK(q[4:0], 5'h0B)
    stop <= 1'h0;
    stop_m = 0;
    repeat (4) @(posedge clk_i);
    `CHK(en, 1'h1)
    wb(1'h1, CTRL_OFS, 32'h1, q);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h1;
    @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    wb(1'h0, STAT_OFS, 32'h0, q);
    `CHK(q[0], 1'h0)
    tally_and_finish();
  end
endmodule : card_disable_bench
